// ===== hw/ipw_widget.sv
// input pin widget: link verb receiver, registers, responses
`timescale 1ns/1ps
module ipw_widget import ipw_pkg::*; #(
    parameter logic [3:0] CODEC_ADDR = 4'h0,
    parameter logic [7:0] NODE_ID = WIDGET_NODE
) (
    input wire logic mclk,            // 200 mhz core clock
    input wire logic rst,             // power-on reset
    input wire logic link_bclk,       // link bit clock pin
    input wire logic link_sync,       // frame sync pin
    input wire logic link_sdo,        // command data pin
    input wire logic link_rst_n,      // link reset pin
    output logic link_sdi,            // response data out
    output logic link_sdi_oe,         // response drive enable
    input wire logic fg_reset,        // group reset pulse
    input wire logic [1:0] fg_power,  // group power state
    input wire logic presence_pin,    // jack sense pin
    output logic ext_amp_pin,         // external amp control
    output logic input_enable,        // input path on
    output ipw_bias_t bias_mode,      // decoded bias level
    output logic wake              // wake event pulse
);
    // bias code decode
    function automatic ipw_bias_t bias_decode(input logic [2:0] c);
        case (c)
            3'h0: bias_decode = BIAS_HIZ;
            3'h1: bias_decode = BIAS_HALF;
            3'h2: bias_decode = BIAS_GND;
            3'h4: bias_decode = BIAS_P80;
            3'h5: bias_decode = BIAS_FULL;
            default: bias_decode = BIAS_RSVD;
        endcase
    endfunction : bias_decode

    logic [4:0] meta_r;        // first sync stage
    logic [4:0] pin_r;         // second sync stage
    logic bclk_d_r;            // bit clock history
    logic pres_d_r;            // presence history
    logic bclk_s, sync_s, sdo_s, pres_s, lrst_n_s;
    logic bclk_rise;
    logic soft_rst;            // group or link reset

    // two-flop sync of every pin, then one edge-history stage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_r <= 5'h01;   // link reset pin idles high: no false link reset
            pin_r <= 5'h01;
            bclk_d_r <= 1'b0;
            pres_d_r <= 1'b0;
        end else begin
            meta_r <= {link_bclk, link_sync, link_sdo, presence_pin,
                link_rst_n};
            pin_r <= meta_r;
            bclk_d_r <= bclk_s;  // history reads only the second stage
            pres_d_r <= pres_s;
        end
    end
    assign {bclk_s, sync_s, sdo_s, pres_s, lrst_n_s} = pin_r;
    assign bclk_rise = bclk_s & ~bclk_d_r;
    assign soft_rst = fg_reset | ~lrst_n_s;
    // command receiver
    logic in_frame_r;
    logic [5:0] bit_cnt_r;
    logic [CMD_BITS-1:0] cmd_sr_r;
    logic cmd_done_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_frame_r <= 1'b0;
            bit_cnt_r <= 6'h00;
            cmd_sr_r <= '0;
            cmd_done_r <= 1'b0;
        end else if (!lrst_n_s) begin
            in_frame_r <= 1'b0;  // no frames under link reset
            bit_cnt_r <= 6'h00;
            cmd_done_r <= 1'b0;
        end else begin
            cmd_done_r <= 1'b0;
            if (bclk_rise && sync_s) begin
                in_frame_r <= 1'b1;
                bit_cnt_r <= 6'h00;
            end else if (bclk_rise && in_frame_r) begin
                cmd_sr_r <= {cmd_sr_r[CMD_BITS-2:0], sdo_s};
                bit_cnt_r <= bit_cnt_r + 6'h01;
                if (bit_cnt_r == 6'(CMD_BITS - 1)) begin
                    in_frame_r <= 1'b0;
                    cmd_done_r <= 1'b1;
                end
            end
        end
    end
    ipw_cmd_t cmd;
    logic hit;
    logic [11:0] v12;
    logic [7:0] pl8;
    logic [15:0] pl16;
    assign cmd = ipw_cmd_t'(cmd_sr_r);
    assign hit = cmd_done_r & (cmd.cad == CODEC_ADDR)
        & (cmd.node_id == NODE_ID);
    assign v12 = cmd.verb[19:8];
    assign pl8 = cmd.verb[7:0];
    assign pl16 = cmd.verb[15:0];
    // register state
    logic [1:0] gain_l_r, gain_r_r;
    logic in_en_r;
    logic [2:0] bias_r;
    logic unsol_en_r;
    logic [5:0] label_r;
    logic ext_amp_r;
    logic [1:0] pwr_req_r, pwr_act_r;
    logic pwr_err_r, pwr_valid_r;
    logic lost_r;              // settings_lost_flag
    ipw_cfg_t cfg_r;
    // write strobes and read word
    logic wr_any, wr_amp, wr_pwr, wr_pin, wr_unsol, wr_xamp, wr_cfg, rd_pwr;
    logic [31:0] rd_data;
    always_comb begin
        wr_amp = hit && cmd.verb[19:16] == V_SET_AMP;
        wr_pwr = hit && v12 == V_SET_PWR;
        wr_pin = hit && v12 == V_SET_PIN;
        wr_unsol = hit && v12 == V_SET_UNSOL;
        wr_xamp = hit && v12 == V_SET_XAMP;
        wr_cfg = hit && v12[11:2] == V_SET_CFG[11:2];
        // any set verb, known or not, counts
        wr_any = hit && (cmd.verb[19:16] == V_SET_AMP
            || v12[11:8] == V_SET_PWR[11:8]);
        rd_pwr = hit && v12 == V_GET_PWR;
        rd_data = 32'h0000_0000;       // unknown verbs read zero
        if (cmd.verb[19:16] == V_GET_AMP) begin
            // input side only; output amp absent
            if (!pl16[AMP_GET_OUT]) begin
                rd_data = {30'h0, pl16[AMP_LEFT] ? gain_l_r : gain_r_r};
            end
        end else begin
            case (v12)
                V_GET_PARAM: begin
                    if (pl8 == P_WIDGET_CAPS) begin
                        rd_data = WIDGET_CAPS_WORD;
                    end else if (pl8 == P_PIN_CAPS) begin
                        rd_data = PIN_CAPS_WORD;
                    end
                end
                V_GET_PWR: rd_data = {21'h0, lost_r, 1'b0, pwr_err_r,
                    2'h0, pwr_act_r, 2'h0, pwr_req_r};
                // output enable bit 6 is always zero
                V_GET_PIN: rd_data = {25'h0, 1'b0, in_en_r, 2'h0,
                    bias_r};
                V_GET_UNSOL: rd_data = {24'h0, unsol_en_r, 1'b0, label_r};
                V_GET_SENSE: rd_data = {pres_s, 31'h0};
                V_GET_XAMP: rd_data = {30'h0, ext_amp_r, 1'b0};
                default: begin
                    if (v12[11:2] == V_GET_CFG[11:2]) begin
                        rd_data = {24'h0, cfg_r[8*v12[1:0] +: 8]};
                    end
                end
            endcase
        end
    end
    // volatile settings: every reset clears them, except amp control, which resets to one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gain_l_r <= 2'h0;
            gain_r_r <= 2'h0;
            in_en_r <= 1'b0;
            bias_r <= 3'h0;
            unsol_en_r <= 1'b0;
            label_r <= 6'h00;
            ext_amp_r <= 1'b1;
        end else if (soft_rst) begin
            gain_l_r <= 2'h0;
            gain_r_r <= 2'h0;
            in_en_r <= 1'b0;
            bias_r <= 3'h0;
            unsol_en_r <= 1'b0;
            label_r <= 6'h00;
            ext_amp_r <= 1'b1;
        end else begin
            if (wr_amp && pl16[AMP_SET_IN]) begin
                if (pl16[AMP_LEFT]) begin
                    gain_l_r <= pl16[1:0];
                end
                if (pl16[AMP_RIGHT]) begin
                    gain_r_r <= pl16[1:0];
                end
            end
            if (wr_pin) begin
                in_en_r <= pl8[5];
                bias_r <= pl8[2:0];
            end
            if (wr_unsol) begin
                unsol_en_r <= pl8[7];
                label_r <= pl8[5:0];
            end
            if (wr_xamp) begin
                ext_amp_r <= pl8[1];
            end
        end
    end

    // power state: reset reaches D3; a power set makes reached = deeper of request and group
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwr_req_r <= PWR_D0;
            pwr_act_r <= PWR_D3;
            pwr_err_r <= 1'b0;
            pwr_valid_r <= 1'b0;
        end else if (soft_rst) begin
            pwr_req_r <= PWR_D0;             // sync reset kept out of the async branch
            pwr_act_r <= PWR_D3;
            pwr_err_r <= 1'b0;
            pwr_valid_r <= 1'b0;
        end else begin
            if (wr_pwr) begin
                pwr_req_r <= pl8[1:0];
                pwr_valid_r <= 1'b1;
            end
            if (pwr_valid_r) begin
                pwr_act_r <= (fg_power > pwr_req_r) ? fg_power : pwr_req_r;
                pwr_err_r <= fg_power > pwr_req_r;
            end
        end
    end
    // settings lost: reset sets, access clears; set wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lost_r <= 1'b1;
        end else if (soft_rst) begin
            lost_r <= 1'b1;
        end else if (rd_pwr || wr_any) begin
            lost_r <= 1'b0;
        end
    end

    // default configuration, power-on reset only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_r <= CFG_RST;
        end else if (wr_cfg) begin
            cfg_r[8*v12[1:0] +: 8] <= pl8;
        end
    end

    // presence change event, gated by enable and override
    logic jd_override;
    logic pres_evt;
    logic unsol_pend_r;
    logic wake_r;
    assign jd_override = cfg_r.misc[CFG_MISC_LSB - 8];
    assign pres_evt = (pres_s ^ pres_d_r) & ~jd_override
        & unsol_en_r;
    // response pending and serial transmitter
    logic resp_pend_r;
    logic [31:0] resp_r;
    logic [RESP_BITS-1:0] tx_sr_r;
    logic [5:0] tx_cnt_r;
    logic frame_start;
    assign frame_start = bclk_rise & sync_s & lrst_n_s;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resp_pend_r <= 1'b0;
            resp_r <= 32'h0000_0000;
        end else if (hit) begin
            resp_pend_r <= 1'b1;             // new answer wins
            resp_r <= rd_data;
        end else if (frame_start || !lrst_n_s) begin
            resp_pend_r <= 1'b0;
        end
    end

    // unsolicited pending; event wins over the send
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            unsol_pend_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            wake_r <= pres_evt;
            if (pres_evt) begin
                unsol_pend_r <= 1'b1;
            end else if (soft_rst) begin
                unsol_pend_r <= 1'b0;
            end else if (frame_start && !resp_pend_r) begin
                unsol_pend_r <= 1'b0;
            end
        end
    end
    // shift out msb first; solicited answer first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_sr_r <= '0;
            tx_cnt_r <= 6'h00;
        end else if (!lrst_n_s) begin
            tx_sr_r <= '0;
            tx_cnt_r <= 6'h00;
        end else if (frame_start) begin
            if (resp_pend_r) begin
                tx_sr_r <= {1'b1, 1'b0, resp_r};
                tx_cnt_r <= 6'(RESP_BITS);
            end else if (unsol_pend_r) begin
                tx_sr_r <= {1'b1, 1'b1, label_r, 26'h0};
                tx_cnt_r <= 6'(RESP_BITS);
            end else begin
                tx_sr_r <= '0;
                tx_cnt_r <= 6'h00;
            end
        end else if (bclk_rise && tx_cnt_r != 6'h00) begin
            tx_sr_r <= {tx_sr_r[RESP_BITS-2:0], 1'b0};
            tx_cnt_r <= tx_cnt_r - 6'h01;
        end
    end

    // enable flop tracks the count
    logic sdi_oe_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdi_oe_r <= 1'b0;
        end else begin
            sdi_oe_r <= tx_cnt_r != 6'h00;
        end
    end

    // pin outputs; amp driven only in full power
    logic ext_amp_pin_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_amp_pin_r <= 1'b0;
        end else begin
            ext_amp_pin_r <= ext_amp_r
                && pwr_act_r == PWR_D0;
        end
    end

    assign link_sdi = tx_sr_r[RESP_BITS-1] & sdi_oe_r;
    assign link_sdi_oe = sdi_oe_r;
    assign ext_amp_pin = ext_amp_pin_r;
    assign input_enable = in_en_r;
    assign bias_mode = bias_decode(bias_r);
    assign wake = wake_r;
endmodule : ipw_widget

// ===== hw/ipw_pkg.sv
// constants and types for the input pin widget verb block
// Notes on behaviour
// - capabilities word type field is pin complex
// - capabilities: power, unsolicited, input amp, stereo
// - pin caps: bias mask, amp control, input, presence
// - left and right gain stored, read back
// - power request stored, reached state reported
// - error bit when a written power request is not reached
// - settings-lost flag cleared by power get, sets
// - input enable writable, output enable reads zero
// - bias select decoded; host uses advertised codes
// - unsolicited enable gates responses and wake events
// - label placed in unsolicited response top bits
// - presence in bit 31, rest zero
// - amp control resets one, drives pin when powered
// - default configuration written bytewise, connectivity resets
// - location field resets to zero
// - device kind resets other, type, color zero
// - misc bit zero overrides jack detect; association, sequence
package ipw_pkg;
    localparam int CMD_BITS = 32;             // verb bits after sync
    localparam int RESP_BITS = 34;            // valid, unsol, data
    localparam logic [7:0] WIDGET_NODE = 8'h0c;
    // 12-bit verbs, 4-bit amp verbs, parameter ids
    localparam logic [11:0] V_GET_PARAM = 12'hf00;
    localparam logic [11:0] V_SET_PWR = 12'h705;
    localparam logic [11:0] V_GET_PWR = 12'hf05;
    localparam logic [11:0] V_SET_PIN = 12'h707;
    localparam logic [11:0] V_GET_PIN = 12'hf07;
    localparam logic [11:0] V_SET_UNSOL = 12'h708;
    localparam logic [11:0] V_GET_UNSOL = 12'hf08;
    localparam logic [11:0] V_GET_SENSE = 12'hf09;
    localparam logic [11:0] V_SET_XAMP = 12'h70c;
    localparam logic [11:0] V_GET_XAMP = 12'hf0c;
    localparam logic [11:0] V_SET_CFG = 12'h71c;  // .. 71f
    localparam logic [11:0] V_GET_CFG = 12'hf1c;  // .. f1f
    localparam logic [3:0] V_SET_AMP = 4'h3;
    localparam logic [3:0] V_GET_AMP = 4'hb;
    localparam logic [7:0] P_WIDGET_CAPS = 8'h09;
    localparam logic [7:0] P_PIN_CAPS = 8'h0c;
    // amp payload bits
    localparam int AMP_GET_OUT = 15;
    localparam int AMP_SET_IN = 14;
    localparam int AMP_LEFT = 13;
    localparam int AMP_RIGHT = 12;
    // capability words
    localparam logic [31:0] WIDGET_CAPABILITIES_TYPE_PIN = 32'h0040_0000;
    localparam logic [31:0] WIDGET_CAPABILITIES_PWR = 32'h0000_0400;
    localparam logic [31:0] WIDGET_CAPABILITIES_UNSOL = 32'h0000_0080;
    localparam logic [31:0] WIDGET_CAPABILITIES_INAMP = 32'h0000_0002;
    localparam logic [31:0] WIDGET_CAPABILITIES_STEREO = 32'h0000_0001;
    localparam logic [31:0] WIDGET_CAPS_WORD = WIDGET_CAPABILITIES_TYPE_PIN | WIDGET_CAPABILITIES_PWR
        | WIDGET_CAPABILITIES_UNSOL | WIDGET_CAPABILITIES_INAMP | WIDGET_CAPABILITIES_STEREO;
    localparam logic [7:0] BIAS_SUPPORT_MASK = 8'h17;
    localparam logic [31:0] PIN_CAPS_WORD = 32'h0001_0000
        | {16'h0000, BIAS_SUPPORT_MASK, 8'h00} | 32'h0000_0024;
    // default configuration fields, power states
    localparam logic [1:0] CFG_CONN_NONE = 2'h1;
    localparam logic [5:0] CFG_LOC_RST = 6'h00;
    localparam logic [3:0] CFG_DEV_OTHER = 4'hf;
    localparam logic [3:0] CFG_ASSOC_RST = 4'hf;
    localparam int CFG_MISC_LSB = 8;          // jack detect override
    localparam logic [1:0] PWR_D0 = 2'h0;
    localparam logic [1:0] PWR_D3 = 2'h3;

    typedef struct packed {
        logic [3:0] cad;       // codec address
        logic [7:0] node_id;   // target node
        logic [19:0] verb;     // verb and payload
    } ipw_cmd_t;

    typedef struct packed {
        logic [1:0] conn;      // port_connection_kind
        logic [1:0] chassis;   // location upper
        logic [3:0] position;  // location lower
        logic [3:0] device;
        logic [3:0] conn_type;
        logic [3:0] color;
        logic [3:0] misc;
        logic [3:0] assoc;
        logic [3:0] seq;
    } ipw_cfg_t;

    localparam ipw_cfg_t CFG_RST = '{conn: CFG_CONN_NONE,
        chassis: CFG_LOC_RST[5:4], position: CFG_LOC_RST[3:0],
        device: CFG_DEV_OTHER, conn_type: 4'h0, color: 4'h0,
        misc: 4'h0, assoc: CFG_ASSOC_RST, seq: 4'h0};

    typedef enum logic [2:0] {
        BIAS_HIZ, BIAS_HALF, BIAS_GND, BIAS_P80, BIAS_FULL, BIAS_RSVD
    } ipw_bias_t;
endpackage : ipw_pkg

// ===== verif/ipw_widget_asserts.sv
// checker: link answer framing, soft resets and wake pulses
`timescale 1ns/1ps
module ipw_widget_asserts import ipw_pkg::*; (
    input wire logic mclk, // core clock
    input wire logic rst, // power-on reset
    input wire logic link_bclk, // bit clock
    input wire logic link_sync, // frame sync
    input wire logic link_rst_n, // link reset
    input wire logic link_sdi, // answer bits
    input wire logic link_sdi_oe, // answer enable
    input wire logic fg_reset, // group reset
    input wire logic presence_pin, // jack sense
    input wire logic ext_amp_pin, // amp pin
    input wire logic input_enable, // input path
    input wire ipw_bias_t bias_mode, // bias level
    input wire logic wake // wake pulse
);
    logic bclk_r; // last bit clock sample
    logic pres_r; // last jack sample
    logic [7:0] sync_age_r; // cycles since a sync rise
    logic [5:0] bit_cnt_r; // rises while answering
    logic [3:0] chg_age_r; // cycles since jack moved
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // raw pins sampled here, so the ages below carry some slack
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bclk_r <= 1'b0;
            pres_r <= 1'b0;
        end else begin
            bclk_r <= link_bclk;
            pres_r <= presence_pin;
        end
    end
    // age of the last frame start, saturating
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) sync_age_r <= 8'hff;
        else if (link_bclk && !bclk_r && link_sync) sync_age_r <= 8'h00;
        else if (sync_age_r != 8'hff) sync_age_r <= sync_age_r + 8'h01;
    end
    // bit clock rises seen while the answer is driven
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) bit_cnt_r <= 6'h00;
        else if (!link_sdi_oe) bit_cnt_r <= 6'h00;
        else if (link_bclk && !bclk_r) bit_cnt_r <= bit_cnt_r + 6'h01;
    end
    // age of the last jack change
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) chg_age_r <= 4'hf;
        else if (presence_pin != pres_r) chg_age_r <= 4'h0;
        else if (chg_age_r != 4'hf) chg_age_r <= chg_age_r + 4'h1;
    end
    property p_oe_len;
        $fell(link_sdi_oe) |-> bit_cnt_r == 6'd34;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("answer not 34 bits long");
    property p_oe_start;
        $rose(link_sdi_oe) |-> link_sdi && sync_age_r <= 8'd8;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("answer start off frame");
    property p_sdi_quiet;
        !link_sdi_oe |-> !link_sdi;
    endproperty
    a_sdi_quiet: assert property (p_sdi_quiet) else $error("data while not driving");
    property p_fg_amp;
        fg_reset |-> ##[1:3] !ext_amp_pin;
    endproperty
    a_fg_amp: assert property (p_fg_amp) else $error("amp pin high after group reset");
    property p_fg_input;
        fg_reset |-> ##[1:3] (!input_enable && bias_mode == BIAS_HIZ);
    endproperty
    a_fg_input: assert property (p_fg_input) else $error("pin control kept on group reset");
    property p_link_rst;
        $fell(link_rst_n) |-> ##[2:6] (!input_enable && !ext_amp_pin);
    endproperty
    a_link_rst: assert property (p_link_rst) else $error("link reset not applied");
    property p_wake_one;
        wake |=> !wake;
    endproperty
    a_wake_one: assert property (p_wake_one) else $error("wake longer than a cycle");
    property p_wake_cause;
        wake |-> chg_age_r <= 4'd8;
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without jack change");
endmodule : ipw_widget_asserts

bind ipw_widget ipw_widget_asserts i_ipw_widget_asserts (.mclk(mclk), .rst(rst), .link_bclk(link_bclk),
    .link_sync(link_sync), .link_rst_n(link_rst_n), .link_sdi(link_sdi), .link_sdi_oe(link_sdi_oe),
    .fg_reset(fg_reset), .presence_pin(presence_pin), .ext_amp_pin(ext_amp_pin),
    .input_enable(input_enable), .bias_mode(bias_mode), .wake(wake));

// ===== verif/ipw_host_model.sv
// host controller model: command frames out, answers in
`timescale 1ns/1ps
module ipw_host_model (
    output logic link_bclk, // bit clock, still between frames
    output logic link_sync, // frame marker
    output logic link_sdo, // command bits
    input wire logic link_sdi, // answer bits
    input wire logic link_sdi_oe // answer enable
);
    localparam realtime BCLK_HALF = 62.5; // 125 ns bit clock
    initial begin
        link_bclk = 1'b0;
        link_sync = 1'b0;
        link_sdo = 1'b0;
    end
    // rise 0 carries sync, rises 1..32 the command msb first;
    // answer bits are taken on falls, half a period after they change
    task automatic frame(input logic [31:0] cmd, output logic [33:0] rsp, output logic got);
        rsp = '0;
        got = 1'b0;
        link_sync = 1'b1;
        for (int k = 0; k < 35; k++) begin
            #(BCLK_HALF) link_bclk = 1'b1;
            #(BCLK_HALF) link_bclk = 1'b0;
            if (k == 0) got = (link_sdi_oe === 1'b1);
            if (k < 34) rsp = {rsp[32:0], link_sdi};
            link_sync = 1'b0;
            // bit for the next rise; past the last bit the line toggles
            link_sdo = (k < 32) ? cmd[31-k] : ~link_sdo;
        end
    endtask : frame
endmodule : ipw_host_model

// ===== verif/tb_top.sv
// bench: verb frames from the host model into the pin widget
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top import ipw_pkg::*; ;
    localparam logic [31:0] IDLE_CMD = {4'h1, WIDGET_NODE, 20'hf0009}; // other codec, ignored
    localparam logic [7:0] CFG_BYTES [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    localparam ipw_bias_t BIAS_TAB [8] = '{BIAS_HIZ, BIAS_HALF, BIAS_GND, BIAS_RSVD,
        BIAS_P80, BIAS_FULL, BIAS_RSVD, BIAS_RSVD};
    // get verb and answer after power-on; power get last, it clears the flag
    localparam logic [51:0] RST_TAB [12] = '{
        {20'hf0009, 32'h0040_0483},
        {20'hf000c, 32'h0001_1724},
        {20'hb2000, 32'h0},
        {20'hb0000, 32'h0},
        {20'hf0700, 32'h0},
        {20'hf0800, 32'h0},
        {20'hf0900, 32'h0},
        {20'hf0c00, 32'h2},
        {20'hf1c00, 32'hf0},
        {20'hf1e00, 32'hf0},
        {20'hf1f00, 32'h40},
        {20'hf0500, 32'h430}
    };
    logic mclk = 1'b0; // core clock
    logic rst = 1'b1; // power-on reset
    logic link_rst_n = 1'b1; // link reset
    logic fg_reset = 1'b0; // group reset
    logic [1:0] fg_power = PWR_D0; // group power
    logic presence_pin = 1'b0; // jack sense
    logic link_bclk, link_sync, link_sdo, link_sdi, link_sdi_oe;
    logic ext_amp_pin, input_enable, wake;
    ipw_bias_t bias_mode; // decoded bias
    logic [33:0] rsp; // last frame's answer
    logic got; // answer seen in last frame
    int checks = 0;
    int fail_count = 0;
    int wake_cnt = 0;
    always #2.5 mclk = ~mclk;
    // count wake pulses
    always @(posedge mclk) begin
        if (wake === 1'b1) wake_cnt++;
    end
    ipw_widget i_ipw_widget (.mclk(mclk), .rst(rst), .link_bclk(link_bclk), .link_sync(link_sync),
        .link_sdo(link_sdo), .link_rst_n(link_rst_n), .link_sdi(link_sdi), .link_sdi_oe(link_sdi_oe),
        .fg_reset(fg_reset), .fg_power(fg_power), .presence_pin(presence_pin), .ext_amp_pin(ext_amp_pin),
        .input_enable(input_enable), .bias_mode(bias_mode), .wake(wake));
    ipw_host_model i_ipw_host_model (.link_bclk(link_bclk), .link_sync(link_sync), .link_sdo(link_sdo),
        .link_sdi(link_sdi), .link_sdi_oe(link_sdi_oe));
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    // set verb; its answer is dropped by the next frame
    task automatic put(input logic [19:0] verb);
        i_ipw_host_model.frame({4'h0, WIDGET_NODE, verb}, rsp, got);
        tick(1);
    endtask : put
    // frame for another codec; carries any pending answer back
    task automatic idle();
        i_ipw_host_model.frame(IDLE_CMD, rsp, got);
        tick(1);
    endtask : idle
    task automatic rd(input logic [19:0] verb, input logic [31:0] exp);
        put(verb);
        idle();
        `CHK(rsp, {2'b10, exp})
    endtask : rd
    task automatic conclude();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    // hang guard
    initial begin
        #460000;
        fail_count++;
        conclude();
    end
    initial begin
        tick(4);
        rst = 1'b0;
        tick(3);
        foreach (RST_TAB[i]) rd(RST_TAB[i][51:32], RST_TAB[i][31:0]);
        rd(20'hf0500, 32'h030);
        put(20'h3_6002);
        put(20'h3_5001);
        rd(20'hb2000, 32'h2);
        rd(20'hb0000, 32'h1);
        // every advertised bias code only, output enable asked each time
        for (int c = 0; c < 8; c++) begin
            if (BIAS_SUPPORT_MASK[c]) begin
                put({12'h707, 8'h60 | 8'(c)});
                `CHK(bias_mode, BIAS_TAB[c])
            end
        end
        `CHK(input_enable, 1'b1)
        rd(20'hf0700, 32'h24);
        put(20'h705_00);
        rd(20'hf0500, 32'h0);
        `CHK(ext_amp_pin, 1'b1)
        put(20'h70c_00);
        `CHK(ext_amp_pin, 1'b0)
        put(20'h70c_02);
        // group held deeper than the request
        fg_power = PWR_D3;
        put(20'h705_01);
        rd(20'hf0500, 32'h131);
        `CHK(ext_amp_pin, 1'b0)
        fg_power = PWR_D0;
        put(20'h705_00);
        rd(20'hf0500, 32'h0);
        `CHK(ext_amp_pin, 1'b1)
        // unsolicited answer carries the label once enabled; none after disable
        put(20'h708_ab);
        idle();
        presence_pin = 1'b1;
        idle();
        `CHK(rsp, {2'b11, 6'h2b, 26'h0})
        `CHK(wake_cnt, 1)
        rd(20'hf0900, 32'h8000_0000);
        put(20'h708_2b);
        idle();
        presence_pin = 1'b0;
        idle();
        `CHK(got, 1'b0)
        // override on: enabled but quiet
        put(20'h71d_01);
        put(20'h708_ab);
        idle();
        presence_pin = 1'b1;
        idle();
        `CHK(got, 1'b0)
        `CHK(wake_cnt, 1)
        for (int b = 0; b < 4; b++) put({12'h71c + 12'(b), CFG_BYTES[b]});
        for (int b = 0; b < 4; b++) rd({12'hf1c + 12'(b), 8'h00}, {24'h0, CFG_BYTES[b]});
        // group reset: volatile settings return, configuration stays
        fg_reset = 1'b1;
        tick(1);
        fg_reset = 1'b0;
        rd(20'hb2000, 32'h0);
        rd(20'hf1f00, 32'hc3);
        put(20'h3_6003);
        rd(20'hf0500, 32'h030);
        put(20'h707_20);
        put(20'h705_00);
        link_rst_n = 1'b0;
        tick(10);
        link_rst_n = 1'b1;
        tick(5);
        rd(20'hb2000, 32'h0);
        rd(20'hf0500, 32'h430);
        rd(20'hf1c00, 32'h5a);
        conclude();
    end
endmodule : tb_top
